// >>> inc/cei_consts.vh
// Constants for the charger event interrupt and serial register block
`ifndef CEI_CONSTS_VH
`define CEI_CONSTS_VH
`define CEI_SLAVE_ADDR      7'h4B
`define CEI_LAST_REG        8'h0D
`define CEI_UNMAPPED_DATA   8'hFF
`define CEI_PULSE_NS        256000
`define CEI_CLK_NS          5
`define CEI_PULSE_CYCLES    (`CEI_PULSE_NS / `CEI_CLK_NS)
`define CEI_POOR_RETRIES    3'd7
`define CEI_NSRC            14
// Register indices
`define CEI_REG_BATTERY_REGULATION_VOLTAGE        8'h00
`define CEI_REG_CHARGE_CURRENT_SETTING        8'h01
`define CEI_REG_VIN         8'h02
`define CEI_REG_IIN         8'h03
`define CEI_REG_RSVD        8'h04
`define CEI_REG_CTRL1       8'h05
`define CEI_REG_CTRL2       8'h06
`define CEI_REG_INT_STAT    8'h07
`define CEI_REG_FLT_STAT    8'h08
`define CEI_REG_INT_FLAG    8'h09
`define CEI_REG_FLT_FLAG    8'h0A
`define CEI_REG_INT_MASK    8'h0B
`define CEI_REG_FLT_MASK    8'h0C
`define CEI_REG_PART        8'h0D
// Reset values
`define CEI_RST_BATTERY_REGULATION_VOLTAGE        8'hAA
`define CEI_RST_CHARGE_CURRENT_SETTING        8'h46
`define CEI_RST_VIN         8'h04
`define CEI_RST_IIN         8'h13
`define CEI_RST_CTRL1       8'h00
`define CEI_RST_CTRL2       8'h01
// Control bit: charge enable in control 2
`define CEI_BIT_CHG_EN      0
// Thermal limit field in control 1, bits 1:0
`define CEI_TLIM_LSB        0
`define CEI_TLIM_MSB        1
`endif

// >>> rtl/cei_i2c_slave.v
// Serial register port: two-wire slave with auto-incrementing register pointer
`timescale 1ns/100ps
`default_nettype none
`include "cei_consts.vh"
module cei_i2c_slave (
  input  wire       clk,
  input  wire       srst,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_oe_n,
  output reg        bus_busy,
  output reg  [7:0] reg_addr,
  output reg        wr_stb,
  output reg  [7:0] wr_data,
  output reg        rd_stb,
  input  wire [7:0] rd_data
);
  localparam ST_IDLE = 3'd0;
  localparam ST_DEV  = 3'd1;
  localparam ST_REG  = 3'd2;
  localparam ST_WR   = 3'd3;
  localparam ST_RD   = 3'd4;

  reg  [1:0] scl_sync;
  reg  [1:0] sda_sync;
  reg        scl_q;
  reg        sda_q;
  reg  [2:0] state;
  reg  [3:0] bit_cnt;
  reg  [7:0] shift;
  reg        ack_phase;
  reg        read_dir;
  reg        master_nack;
  reg        rd_reload;
  wire       scl_rise = scl_sync[1] & ~scl_q;
  wire       scl_fall = ~scl_sync[1] & scl_q;
  wire       start_c  = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
  wire       stop_c   = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];

  // Pins pass two flops; oversampling at 200 MHz covers 400 kbit/s
  always @(posedge clk) begin
    if (srst) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      state       <= ST_IDLE;
      bit_cnt     <= 4'd0;
      shift       <= 8'h00;
      ack_phase   <= 1'b0;
      read_dir    <= 1'b0;
      master_nack <= 1'b0;
      rd_reload   <= 1'b0;
      sda_oe_n    <= 1'b1;
      bus_busy    <= 1'b0;
      reg_addr    <= 8'h00;
      wr_stb      <= 1'b0;
      wr_data     <= 8'h00;
      rd_stb      <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (start_c) begin
        bus_busy  <= 1'b1;
        state     <= ST_DEV;
        bit_cnt   <= 4'd0;
        ack_phase <= 1'b0;
        sda_oe_n  <= 1'b1;
      end else if (stop_c) begin
        bus_busy <= 1'b0;
        state    <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end else if (state != ST_IDLE) begin
        if (rd_reload) begin
          // Pointer moved one cycle ago; fetch the next byte while SCL is still low
          rd_reload <= 1'b0;
          shift     <= rd_data;
          rd_stb    <= 1'b1;
          sda_oe_n  <= rd_data[7];
        end else if (scl_rise && !ack_phase) begin
          shift   <= {shift[6:0], sda_sync[1]};
          bit_cnt <= bit_cnt + 4'd1;
        end else if (scl_rise && ack_phase && state == ST_RD) begin
          master_nack <= sda_sync[1];
        end else if (scl_fall) begin
          if (!ack_phase && bit_cnt == 4'd8) begin
            ack_phase <= 1'b1;
            bit_cnt   <= 4'd0;
            case (state)
              ST_DEV: begin
                if (shift[7:1] == `CEI_SLAVE_ADDR) begin
                  sda_oe_n <= 1'b0;
                  read_dir <= shift[0];
                end else begin
                  state <= ST_IDLE;
                end
              end
              ST_REG: begin
                if (shift <= `CEI_LAST_REG) begin
                  sda_oe_n <= 1'b0;
                  reg_addr <= shift;
                end else begin
                  state <= ST_IDLE;
                end
              end
              ST_WR: begin
                sda_oe_n <= 1'b0;
                wr_data  <= shift;
                wr_stb   <= 1'b1;
              end
              ST_RD: begin
                sda_oe_n <= 1'b1;
              end
              default: state <= ST_IDLE;
            endcase
          end else if (ack_phase) begin
            ack_phase <= 1'b0;
            sda_oe_n  <= 1'b1;
            case (state)
              ST_DEV: begin
                if (read_dir) begin
                  state    <= ST_RD;
                  shift    <= rd_data;
                  rd_stb   <= 1'b1;
                  sda_oe_n <= rd_data[7];
                  bit_cnt  <= 4'd0;
                end else begin
                  state <= ST_REG;
                end
              end
              ST_REG: state <= ST_WR;
              ST_WR: reg_addr <= reg_addr + 8'd1;
              ST_RD: begin
                if (master_nack) begin
                  state <= ST_IDLE;
                end else begin
                  reg_addr  <= reg_addr + 8'd1;
                  rd_reload <= 1'b1;
                end
              end
              default: state <= ST_IDLE;
            endcase
          end else if (state == ST_RD && bit_cnt != 4'd0) begin
            // Shifting on each rise leaves the next bit on top
            sda_oe_n <= shift[7];
          end
        end
      end
    end
  end
endmodule  // cei_i2c_slave
`default_nettype wire

// >>> rtl/cei_event_int.v
// Charger event, protection and host interrupt block with serial register port
// Summary of operation
// - Event when a good input source appears or goes away.
// - Event after seven weak-adapter failures, or on capacitor pre-charge failure.
// - Event entering input current, voltage or thermal loop; charge state change.
// - Event on watchdog expiry and once at power-up to signal readiness.
// - Events for input overvolt, thermal shutdown, battery overvolt, cap fault, timer.
// - Every source keeps a live bit, a sticky seen bit and a mask bit.
// - A set mask bit suppresses that source's interrupt pulse.
// - Seen bits clear after host read; set again only on new live edge.
// - Input overvolt stops switching, pulses, sets bits; resumes when cleared.
// - Under-voltage stops switching, clears power good, sets its seen bit.
// - Cap fault stops switching, pulses, sets bits, then tries rebalancing.
// - Failed rebalance sets bits and stays stopped until enable toggles.
// - Outer switch over-current forces inductor discharge for as long as it lasts.
// - Thermal loop reduces current, inhibits termination, halves timer, pulses.
// - Thermal shutdown turns converter off until below hysteresis.
// - Battery overvolt disables charging at once, sets bit, pulses.
// - Slave answers at address 0x4B; direction bit 0 write, 1 read.
// - Reads above the last register return all ones.
// - Standard and fast bit rates supported.
// - Start and stop from master; bus busy between them.
// - Bytes of eight bits, MSB first, then acknowledge.
// - Receiver pulls data low on ninth clock to acknowledge.
// - Each notification is one fixed-length active-low pulse.
// - Undefined register address gets no acknowledge, port returns idle.
// - Multi-byte reads and writes cover all registers.
`timescale 1ns/100ps
`default_nettype none
`include "cei_consts.vh"
module cei_event_int #(
  parameter PULSE_CYCLES = `CEI_PULSE_CYCLES
) (
  input  wire       clk,
  input  wire       srst,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_oe_n,
  output reg        int_n,
  output reg        switching_en,
  output reg        charge_en,
  output reg        inductor_discharge,
  output reg        termination_inhibit,
  output reg        timer_half_rate,
  output reg        charge_current_reduce,
  output reg  [1:0] thermal_limit_setting,
  output reg        bus_busy,
  input  wire       src_good,
  input  wire       weak_adapter_check_fail,
  input  wire       cap_precharge_fail,
  input  wire       input_current_loop,
  input  wire       input_voltage_loop,
  input  wire       thermal_loop,
  input  wire       watchdog_expired,
  input  wire [2:0] charge_state_code,
  input  wire       input_overvolt,
  input  wire       thermal_shutdown,
  input  wire       battery_overvolt,
  input  wire       flying_capacitor_fault,
  input  wire       rebalance_done,
  input  wire       rebalance_ok,
  input  wire       safety_timer_expired,
  input  wire       outer_overcurrent
);
  // Source order: 0 good,1 weak,2 precharge,3 iin,4 vin,5 therm,6 wdog,7 state,
  // 8 vin ovp,9 thermal_shutdown,10 battery_overvolt,11 cap fault,12 timer,13 rebalance fail
  localparam NS = `CEI_NSRC;

  reg  [NS-1:0] live_sync1;
  reg  [NS-1:0] live;
  reg  [NS-1:0] live_q;
  reg  [NS-1:0] seen;
  reg  [NS-1:0] mask;
  reg  [2:0]    state_sync1;
  reg  [2:0]    state_sync;
  reg  [2:0]    state_q;
  reg  [2:0]    state_d;
  reg           state_chg;
  reg  [2:0]    weak_cnt;
  reg           weak_trip;
  reg  [1:0]    weak_sync;
  reg           weak_prev;
  reg  [2:0]    aux_sync1;
  reg  [2:0]    aux_sync;
  reg           power_up;
  reg  [7:0]    regs [0:6];
  reg  [17:0]   pulse_cnt;
  reg           cap_lock;
  reg           en_q;
  reg  [7:0]    rd_data;
  wire [7:0]    i_addr;
  wire          wr_stb;
  wire [7:0]    wr_data;
  wire          rd_stb;
  wire          sda_oe_n_i;
  wire          busy_i;
  wire [NS-1:0] edge_ev;
  wire [NS-1:0] raw_live;
  wire          fire;
  wire          weak_fail_rise = weak_sync[1] & ~weak_prev;
  integer       i;

  assign raw_live = {1'b0, safety_timer_expired, flying_capacitor_fault, battery_overvolt,
                     thermal_shutdown, input_overvolt, 1'b0, watchdog_expired, thermal_loop,
                     input_voltage_loop, input_current_loop, cap_precharge_fail,
                     1'b0, src_good};

  cei_i2c_slave u_port (
    .clk      (clk),
    .srst     (srst),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_oe_n (sda_oe_n_i),
    .bus_busy (busy_i),
    .reg_addr (i_addr),
    .wr_stb   (wr_stb),
    .wr_data  (wr_data),
    .rd_stb   (rd_stb),
    .rd_data  (rd_data)
  );

  // --------------------------------------------------------
  // Live conditions
  // --------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      live_sync1  <= {NS{1'b0}};
      live        <= {NS{1'b0}};
      live_q      <= {NS{1'b0}};
      state_sync1 <= 3'd0;
      state_sync  <= 3'd0;
      state_q     <= 3'd0;
      state_d     <= 3'd0;
      state_chg   <= 1'b0;
      weak_cnt    <= 3'd0;
      weak_trip   <= 1'b0;
    end else begin
      live_sync1  <= raw_live;
      state_sync1 <= charge_state_code;
      state_sync  <= state_sync1;
      state_d     <= state_sync;
      // Bits of the code may land a cycle apart; only a code seen twice counts
      state_chg   <= (state_sync == state_d) && (state_sync != state_q);
      if (state_sync == state_d) begin
        state_q <= state_sync;
      end
      live        <= {cap_lock, live_sync1[12:8], state_chg, live_sync1[6:2], weak_trip, live_sync1[0]};
      live_q      <= live;
      // Count failures in a row; a good source breaks the run
      if (live[0]) begin
        weak_cnt  <= 3'd0;
        weak_trip <= 1'b0;
      end else if (weak_fail_rise) begin
        if (weak_cnt == `CEI_POOR_RETRIES - 3'd1) begin
          weak_trip <= 1'b1;
        end else begin
          weak_cnt <= weak_cnt + 3'd1;
        end
      end
    end
  end

  // Weak-adapter failure input, synchronised separately for its edge
  always @(posedge clk) begin
    if (srst) begin
      weak_sync <= 2'b00;
      weak_prev <= 1'b0;
    end else begin
      weak_sync <= {weak_sync[0], weak_adapter_check_fail};
      weak_prev <= weak_sync[1];
    end
  end

  // Good source: both edges notify; faults and loops notify on entry
  assign edge_ev = (live ^ live_q) & {{(NS-1){1'b0}}, 1'b1}
                 | (live & ~live_q) & {{(NS-1){1'b1}}, 1'b0};

  // --------------------------------------------------------
  // Seen flags, masks and pulse
  // --------------------------------------------------------
  function [7:0] pack_byte;
    input [NS-1:0] v;
    input          hi;
    begin
      pack_byte = hi ? {2'b00, v[13:8]} : v[7:0];
    end
  endfunction

  assign fire = |(edge_ev & ~mask) | power_up;

  always @(posedge clk) begin
    if (srst) begin
      seen      <= {NS{1'b0}};
      power_up  <= 1'b1;
      pulse_cnt <= 18'd0;
      int_n     <= 1'b1;
    end else begin
      power_up <= 1'b0;
      // Set wins over a read-clear in the same cycle
      for (i = 0; i < NS; i = i + 1) begin
        if (edge_ev[i]) begin
          seen[i] <= 1'b1;
        end else if (rd_stb && ((i_addr == `CEI_REG_INT_FLAG && i < 8) ||
                                (i_addr == `CEI_REG_FLT_FLAG && i >= 8))) begin
          seen[i] <= 1'b0;
        end
      end
      if (power_up) begin
        seen[6] <= 1'b1;
      end
      if (pulse_cnt != 18'd0) begin
        pulse_cnt <= pulse_cnt - 18'd1;
        int_n     <= (pulse_cnt == 18'd1);
      end else if (fire) begin
        pulse_cnt <= PULSE_CYCLES[17:0];
        int_n     <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------
  // Registers
  // --------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      regs[0] <= `CEI_RST_BATTERY_REGULATION_VOLTAGE;
      regs[1] <= `CEI_RST_CHARGE_CURRENT_SETTING;
      regs[2] <= `CEI_RST_VIN;
      regs[3] <= `CEI_RST_IIN;
      regs[4] <= 8'h00;
      regs[5] <= `CEI_RST_CTRL1;
      regs[6] <= `CEI_RST_CTRL2;
      mask    <= {NS{1'b0}};
    end else if (wr_stb) begin
      if (i_addr < `CEI_REG_INT_STAT) begin
        regs[i_addr[2:0]] <= wr_data;
      end else if (i_addr == `CEI_REG_INT_MASK) begin
        mask[7:0] <= wr_data;
      end else if (i_addr == `CEI_REG_FLT_MASK) begin
        mask[13:8] <= wr_data[5:0];
      end
    end
  end

  always @* begin
    case (i_addr)
      `CEI_REG_INT_STAT: rd_data = pack_byte(live, 1'b0);
      `CEI_REG_FLT_STAT: rd_data = pack_byte(live, 1'b1);
      `CEI_REG_INT_FLAG: rd_data = pack_byte(seen, 1'b0);
      `CEI_REG_FLT_FLAG: rd_data = pack_byte(seen, 1'b1);
      `CEI_REG_INT_MASK: rd_data = pack_byte(mask, 1'b0);
      `CEI_REG_FLT_MASK: rd_data = pack_byte(mask, 1'b1);
      `CEI_REG_PART:     rd_data = 8'h00;
      default: begin
        if (i_addr < `CEI_REG_INT_STAT) begin
          rd_data = regs[i_addr[2:0]];
        end else begin
          rd_data = `CEI_UNMAPPED_DATA;
        end
      end
    endcase
  end

  // --------------------------------------------------------
  // Protection responses
  // --------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      cap_lock              <= 1'b0;
      en_q                  <= 1'b0;
      aux_sync1             <= 3'd0;
      aux_sync              <= 3'd0;
      switching_en          <= 1'b0;
      charge_en             <= 1'b0;
      inductor_discharge    <= 1'b0;
      termination_inhibit   <= 1'b0;
      timer_half_rate       <= 1'b0;
      charge_current_reduce <= 1'b0;
      thermal_limit_setting <= 2'd0;
      sda_oe_n              <= 1'b1;
      bus_busy              <= 1'b0;
    end else begin
      en_q      <= regs[6][`CEI_BIT_CHG_EN];
      aux_sync1 <= {outer_overcurrent, rebalance_ok, rebalance_done};
      aux_sync  <= aux_sync1;
      // Only a fresh enable edge clears the lock, not a held enable
      if (live[11] && aux_sync[0] && !aux_sync[1]) begin
        cap_lock <= 1'b1;
      end else if (regs[6][`CEI_BIT_CHG_EN] && !en_q) begin
        cap_lock <= 1'b0;
      end
      switching_en <= live[0] & ~live[8] & ~live[9] & ~live[11] & ~cap_lock;
      charge_en    <= regs[6][`CEI_BIT_CHG_EN] & ~live[10] & ~cap_lock;
      inductor_discharge    <= aux_sync[2];
      termination_inhibit   <= live[5] | live[3] | live[4];
      timer_half_rate       <= live[5] | live[3] | live[4];
      charge_current_reduce <= live[5];
      thermal_limit_setting <= regs[5][`CEI_TLIM_MSB:`CEI_TLIM_LSB];
      sda_oe_n <= sda_oe_n_i;
      bus_busy <= busy_i;
    end
  end
endmodule  // cei_event_int
`default_nettype wire

// >>> testbench/cei_host_master.sv
// Behavioural two-wire bus host driving the serial register port
`timescale 1ns/100ps
`default_nettype none
module cei_host_master (
  output logic      scl,
  output logic      sda_rel,
  input  wire logic sda
);
  // Quarter of a 125 ns bus bit
  localparam realtime Q = 31.25;

  initial begin
    scl = 1'h1;
    sda_rel = 1'h1;
  end

  // ----
  // Bus conditions and bits
  // ----
  task automatic start;
    sda_rel = 1'h1;
    #Q scl = 1'h1;
    #Q sda_rel = 1'h0;
    #Q scl = 1'h0;
    #Q;
  endtask

  // Clock stays high afterwards: idle bus, no free-running clock
  task automatic stop;
    sda_rel = 1'h0;
    #Q scl = 1'h1;
    #Q sda_rel = 1'h1;
    #Q;
  endtask

  // Data held over the whole high phase, sampled mid-high
  task automatic clk_bit(input logic b, output logic s);
    sda_rel = b;
    #Q scl = 1'h1;
    #Q s = sda;
    #Q scl = 1'h0;
    #Q;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'h1, s);
    ack = ~s;
  endtask

  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'h1, d[i]);
    end
    clk_bit(last, s);
  endtask
endmodule // cei_host_master
`default_nettype wire

// >>> testbench/cei_event_int_monitor.sv
// Concurrent checks on the charger event interrupt block ports
`timescale 1ns/100ps
`default_nettype none
module cei_event_int_monitor #(
  parameter PULSE_CYCLES = 51200
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_n,
  input wire logic int_n,
  input wire logic switching_en,
  input wire logic charge_en,
  input wire logic inductor_discharge,
  input wire logic termination_inhibit,
  input wire logic timer_half_rate,
  input wire logic charge_current_reduce,
  input wire logic bus_busy,
  input wire logic thermal_loop,
  input wire logic input_overvolt,
  input wire logic thermal_shutdown,
  input wire logic battery_overvolt,
  input wire logic flying_capacitor_fault,
  input wire logic outer_overcurrent
);
  logic [31:0] low_cnt;

  default clocking dc @(posedge clk); endclocking
  default disable iff (srst);

  // ----
  // Low-phase length of the notification
  // ----
  always @(posedge clk) begin
    if (srst || int_n) begin
      low_cnt <= 32'h0000_0000;
    end else begin
      low_cnt <= low_cnt + 32'h0000_0001;
    end
  end

  // ----
  // Assertions
  // ----
  chk_pulse_len: assert property ($rose(int_n) |-> low_cnt == PULSE_CYCLES)
    else $error("notification pulse length wrong");
  chk_overvolt_stop: assert property ($rose(input_overvolt) |-> ##[1:6] !switching_en)
    else $error("switching kept on input overvoltage");
  chk_shutdown_off: assert property ($rose(thermal_shutdown) |-> ##[1:6] !switching_en)
    else $error("converter kept on at shutdown");
  chk_batt_overvolt: assert property ($rose(battery_overvolt) |-> ##[1:6] !charge_en)
    else $error("charging kept on battery overvoltage");
  chk_cap_stop: assert property ($rose(flying_capacitor_fault) |-> ##[1:6] !switching_en)
    else $error("switching kept on capacitor fault");
  chk_oc_discharge: assert property ($rose(outer_overcurrent) |-> ##[1:6] inductor_discharge)
    else $error("no inductor discharge on overcurrent");
  chk_thermal_loop: assert property ($rose(thermal_loop) |-> ##[1:6]
    (termination_inhibit && timer_half_rate && charge_current_reduce))
    else $error("thermal loop effects missing");
  chk_start_busy: assert property (($fell(sda_in) && scl_in) |-> ##[1:8] bus_busy)
    else $error("bus not busy after start");
  chk_stop_free: assert property (($rose(sda_in) && scl_in) |-> ##[1:8] !bus_busy)
    else $error("bus still busy after stop");
  chk_drive_busy: assert property (!sda_oe_n |-> bus_busy)
    else $error("data line pulled outside a frame");

  cover property ($fell(int_n));
  cover property ($fell(sda_oe_n));
  cover property ($rose(input_overvolt));
endmodule // cei_event_int_monitor

bind cei_event_int cei_event_int_monitor #(.PULSE_CYCLES(PULSE_CYCLES)) u_mon (
  .clk, .srst, .scl_in, .sda_in, .sda_oe_n, .int_n, .switching_en, .charge_en,
  .inductor_discharge, .termination_inhibit, .timer_half_rate, .charge_current_reduce,
  .bus_busy, .thermal_loop, .input_overvolt, .thermal_shutdown, .battery_overvolt,
  .flying_capacitor_fault, .outer_overcurrent
);
`default_nettype wire

// >>> testbench/tb_cei_event_int.sv
// Self-checking bench for the charger event interrupt block
`timescale 1ns/100ps
`default_nettype none
`include "cei_consts.vh"
module tb_cei_event_int;
  localparam int PC = 64;
  logic        clk;
  logic        srst;
  logic [15:0] ev;
  logic [7:0]  rb [0:3];
  logic        k;
  logic        q;
  logic        rb_done;
  logic        rb_ok;
  int          err_total;
  int          compares;
  wire logic   scl;
  wire logic   sda_rel;
  wire logic   sda_oe_n;
  wire logic   sda = sda_rel & sda_oe_n;
  wire logic   int_n;
  wire logic   charge_en;
  wire logic   sw_en;
  wire logic [1:0] thermal_limit_setting;
  logic [7:0]  rst_v [0:3] = '{`CEI_RST_BATTERY_REGULATION_VOLTAGE, `CEI_RST_CHARGE_CURRENT_SETTING, `CEI_RST_VIN, `CEI_RST_IIN};
  // Event input index, flag register, expected flag value
  logic [19:0] rows [0:11] = '{20'h0_0901, 20'h2_0904, 20'h3_0908, 20'h4_0910, 20'h5_0920,
    20'h6_0940, 20'h7_0980, 20'hA_0A01, 20'hB_0A02, 20'hC_0A04, 20'hD_0A08, 20'hE_0A10};

  cei_host_master m (.scl(scl), .sda_rel(sda_rel), .sda(sda));

  cei_event_int #(.PULSE_CYCLES(PC)) DUT (
    .clk, .srst, .scl_in(scl), .sda_in(sda), .sda_oe_n, .int_n, .switching_en(sw_en), .charge_en,
    .inductor_discharge(), .termination_inhibit(), .timer_half_rate(), .charge_current_reduce(),
    .thermal_limit_setting, .bus_busy(), .src_good(ev[0]), .weak_adapter_check_fail(ev[1]),
    .cap_precharge_fail(ev[2]), .input_current_loop(ev[3]), .input_voltage_loop(ev[4]),
    .thermal_loop(ev[5]), .watchdog_expired(ev[6]), .charge_state_code(ev[9:7]),
    .input_overvolt(ev[10]), .thermal_shutdown(ev[11]), .battery_overvolt(ev[12]),
    .flying_capacitor_fault(ev[13]), .rebalance_done(rb_done), .rebalance_ok(rb_ok),
    .safety_timer_expired(ev[14]), .outer_overcurrent(ev[15])
  );

  // ----
  // Helpers
  // ----
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_int;
    int n;
    n = 0;
    while (int_n !== 1'h0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n == 2000) begin
      chk(8'h00, 8'h01);
      end_sim;
    end
  endtask

  task automatic rd(input logic [7:0] a, input int n);
    m.start();
    m.wbyte({`CEI_SLAVE_ADDR, 1'h0}, k);
    m.wbyte(a, k);
    m.start();
    m.wbyte({`CEI_SLAVE_ADDR, 1'h1}, k);
    chk({7'h00, k}, 8'h01);
    for (int i = 0; i < n; i++) begin
      m.rbyte(i == n - 1, rb[i]);
    end
    m.stop();
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
    m.start();
    m.wbyte({`CEI_SLAVE_ADDR, 1'h0}, k);
    m.wbyte(a, k);
    chk({7'h00, k}, 8'h01);
    for (int i = 0; i < n; i++) begin
      m.wbyte(d[15 - 8 * i -: 8], k);
    end
    m.stop();
  endtask

  // ----
  // Stimulus
  // ----
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    srst = 1'h1;
    ev = 16'h0000;
    rb_done = 1'h0;
    rb_ok = 1'h0;
    err_total = 0;
    compares = 0;
    repeat (2) @(negedge clk);
    srst = 1'h0;
    wait_int;
    rd(8'h09, 1);
    chk(rb[0], 8'h40);
    rd(8'h00, 4);
    for (int i = 0; i < 4; i++) chk(rb[i], rst_v[i]);
    for (int i = 0; i < 12; i++) begin
      @(negedge clk) ev[rows[i][19:16]] = 1'h1;
      wait_int;
      rd(rows[i][15:8], 1);
      chk(rb[0], rows[i][7:0]);
      rd(rows[i][15:8], 1);
      chk(rb[0], 8'h00);
      @(negedge clk) ev[rows[i][19:16]] = 1'h0;
      repeat (3 * PC) @(negedge clk);
      rd(rows[i][15:8], 1);
    end
    // Six weak-adapter failures stay silent, the seventh notifies
    for (int p = 1; p <= 7; p++) begin
      @(negedge clk) ev[1] = 1'h1;
      repeat (6) @(negedge clk);
      ev[1] = 1'h0;
      repeat (6) @(negedge clk);
      if (p == 6) rd(8'h09, 1);
      if (p == 6) chk(rb[0], 8'h00);
    end
    wait_int;
    rd(8'h09, 1);
    chk(rb[0], 8'h02);
    wr(8'h0B, 16'h0800, 1);
    @(negedge clk) ev[3] = 1'h1;
    q = 1'h1;
    repeat (100) begin
      @(negedge clk);
      if (int_n !== 1'h1) q = 1'h0;
    end
    chk({7'h00, q}, 8'h01);
    ev[3] = 1'h0;
    wr(8'h0B, 16'h0000, 1);
    rd(8'h09, 1);
    m.start();
    m.wbyte({7'h4A, 1'h0}, k);
    m.stop();
    chk({7'h00, k}, 8'h00);
    m.start();
    m.wbyte({`CEI_SLAVE_ADDR, 1'h0}, k);
    m.wbyte(8'h0E, k);
    m.stop();
    chk({7'h00, k}, 8'h00);
    wr(8'h00, 16'h1234, 2);
    rd(8'h00, 2);
    chk(rb[0], 8'h12);
    chk(rb[1], 8'h34);
    rd(8'h0D, 2);
    chk(rb[0], 8'h00);
    chk(rb[1], `CEI_UNMAPPED_DATA);
    wr(8'h05, 16'h0200, 1);
    chk({6'h00, thermal_limit_setting}, 8'h02);
    // Good source on, then overvoltage, then cap faults with good and failed rebalance
    @(negedge clk) ev[0] = 1'h1;
    repeat (20) @(negedge clk);
    chk({7'h00, sw_en}, 8'h01);
    ev[10] = 1'h1;
    repeat (8) @(negedge clk);
    chk({7'h00, sw_en}, 8'h00);
    ev[10] = 1'h0;
    for (int t = 0; t < 2; t++) begin
      repeat (8) @(negedge clk);
      chk({7'h00, sw_en}, 8'h01);
      rb_ok = (t == 0);
      ev[13] = 1'h1;
      rb_done = 1'h1;
      repeat (8) @(negedge clk);
      chk({7'h00, sw_en}, 8'h00);
      rb_done = 1'h0;
      ev[13] = 1'h0;
    end
    repeat (8) @(negedge clk);
    chk({6'h00, sw_en, charge_en}, 8'h00);
    rd(8'h0A, 1);
    chk(rb[0], 8'h29);
    wr(8'h06, 16'h0000, 1);
    chk({7'h00, charge_en}, 8'h00);
    wr(8'h06, 16'h0100, 1);
    chk({7'h00, charge_en}, 8'h01);
    chk({7'h00, sw_en}, 8'h01);
    @(negedge clk) ev[15] = 1'h1;
    repeat (8) @(negedge clk);
    ev[15] = 1'h0;
    srst = 1'h1;
    repeat (2) @(negedge clk);
    srst = 1'h0;
    wait_int;
    rd(8'h00, 1);
    chk(rb[0], `CEI_RST_BATTERY_REGULATION_VOLTAGE);
    end_sim;
  end
endmodule // tb_cei_event_int
`default_nettype wire
